// [hw/pcie_cap_regs_defs.vh]
`ifndef PCIE_CAP_REGS_DEFS_VH
`define PCIE_CAP_REGS_DEFS_VH

// Register indices; the byte address is four times the index
`define IDX_EXP_CAP_HDR 8'he2
`define IDX_DEV_CAP 8'he4
`define IDX_DEV_CTRL 8'he8
`define IDX_DEV_STAT 8'hea
`define IDX_LINK_CAP 8'hec
`define IDX_LINK_CTRL 8'hf0
`define ADDR_W 12
`define IDX_LSB 2

// Register select codes, one-hot
`define SEL_NONE 6'h00
`define SEL_HDR 6'h01
`define SEL_DCAP 6'h02
`define SEL_DCTL 6'h04
`define SEL_DSTA 6'h08
`define SEL_LCAP 6'h10
`define SEL_LCTL 6'h20

// Capability header fields
`define HDR_PORT_TYPE 4'h1
`define HDR_CAP_VER 4'h1

// Device capabilities fixed fields
`define DCAP_L1_ACC_LAT 3'h7
`define DCAP_L0S_ACC_LAT 3'h7
`define DCAP_EXT_TAG 1'h0
`define DCAP_PHANTOM 2'h0
`define DCAP_MPS_SUP 3'h0
`define DCAP_IND_BITS 3'h0

// Device control fields and reset values
`define DCTL_MRRS_HI 14
`define DCTL_MRRS_LO 12
`define DCTL_MRRS_RST 3'h2
`define DCTL_AUX_BIT 10
`define DCTL_MPS_HI 7
`define DCTL_MPS_LO 5
`define DCTL_MPS_128 3'h0
`define DCTL_EN_HI 3
`define DCTL_EN_LO 0
`define MRRS_MAX_CODE 3'h5

// Device status fields
`define DSTA_ERR_HI 3
`define DSTA_ERR_LO 0

// Link capabilities fixed fields
`define LCAP_L1_EXIT 3'h7
`define LCAP_L0S_EXIT 3'h2
`define LCAP_ASPM_SUP 2'h1
`define LCAP_WIDTH 6'h01
`define LCAP_SPEED 4'h1

// Link control fields and reset values
`define LCTL_XSYNC_BIT 7
`define LCTL_CCLK_BIT 6
`define LCTL_ASPM_HI 1
`define LCTL_ASPM_LO 0
`define LCTL_ASPM_RSVD 2'h2
`define LCTL_RCB_128 1'h1

// Payload and request sizes in bytes
`define SIZE_W 13
`define SIZE_128 13'h0080

`endif

// [hw/pcie_endpoint_capability_regs.v]
// Summary of operation
// - Header reads port type 1 (legacy endpoint) and version 1.
// - Slot power scale 27:26 and value 25:18 are read-only, reset 0.
// - Indicator and button presence bits 14:12 read as zero.
// - Acceptable L1 latency reads 0b111 in bits 11:9.
// - Acceptable L0s latency reads 0b111 in bits 8:6.
// - Extended tag bit 5 and phantom bits 4:3 read zero.
// - Supported payload field bits 2:0 reads 0b000 (128 bytes).
// - Read request size bits 14:12, reset 2; requests never exceed it.
// - Payload size bits 7:5 is 128 B; limits receive and transmit.
// - Control bits 11, 9, 8 and 4 stay zero; writes ignored.
// - Aux power enable bit 10 reads 1, only power-on reset restores.
// - Four error reporting enables bits 3:0, reset 0, gate reports.
// - Status bit 5 set while non-posted requests await completion.
// - Status bit 4 shows whether aux power is detected.
// - Error events set status bits 3:0 regardless of enables.
// - Link port number bits 31:24 hardware-initialized, reset 00.
// - L1 exit latency 0b111 bits 17:15, L0s exit 0b010 bits 14:12.
// - Link power management support reads 0b01 in bits 11:10.
// - Maximum width x1 in bits 9:4, speed code 1 in bits 3:0.
// - Link control bit 7 asks for extended sync on L1 exit.
// - Link control bit 6 selects common clock for exit latencies.
// - Completion boundary bit 3 reads 1, meaning 128 bytes.
// - Link control bits 1:0 set power management, 0b10 reserved.
//
// Chosen here: the APB interface to the registers.
`include "pcie_cap_regs_defs.vh"

module pcie_endpoint_capability_regs #(
  parameter PEND_CNT_W = 6,
  parameter [2:0] L0S_EXIT_COMMON = `LCAP_L0S_EXIT,
  parameter [2:0] L0S_EXIT_ASYNC = `LCAP_L0S_EXIT,
  parameter [2:0] L1_EXIT_COMMON = `LCAP_L1_EXIT,
  parameter [2:0] L1_EXIT_ASYNC = `LCAP_L1_EXIT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire func_reset,
  input wire slot_power_set,
  input wire [1:0] slot_power_scale_in,
  input wire [7:0] slot_power_value_in,
  input wire [7:0] port_number_in,
  input wire aux_power_present,
  input wire np_request_issued,
  input wire np_completion_done,
  input wire err_unsupported,
  input wire err_fatal,
  input wire err_nonfatal,
  input wire err_correctable,
  input wire [`SIZE_W-1:0] rx_payload_len,
  input wire rx_payload_valid,
  output reg rx_payload_oversize,
  output reg [`SIZE_W-1:0] read_request_limit,
  output reg [`SIZE_W-1:0] payload_limit,
  output reg report_unsupported,
  output reg report_fatal,
  output reg report_nonfatal,
  output reg report_correctable,
  output reg extended_sync,
  output reg common_clock,
  output reg [1:0] aspm_control,
  output reg aux_pm_enable,
  output reg [2:0] l0s_exit_code,
  output reg [2:0] l1_exit_code
);

  reg [2:0] mrrs_reg;
  reg [2:0] mps_reg;
  reg [3:0] err_en_reg;
  reg [3:0] err_stat_reg;
  reg [3:0] err_stat_next;
  reg [1:0] slot_scale_reg;
  reg [7:0] slot_value_reg;
  reg [7:0] port_num_reg;
  reg aux_det_reg;
  reg xsync_reg;
  reg cclk_reg;
  reg [1:0] aspm_reg;
  reg aux_en_reg;
  reg [31:0] rdata_next;
  wire pending;
  wire [5:0] sel;
  wire setup_phase;
  wire wr_en;
  wire [3:0] err_events;
  wire [3:0] w1c;

  // One-hot select from an APB byte address; zero when unmapped
  function [5:0] reg_select;
    input [`ADDR_W-1:0] addr;
    begin
      reg_select = `SEL_NONE;
      if (addr[`IDX_LSB-1:0] == 2'h0) begin
        case (addr[`ADDR_W-1:`IDX_LSB])
          {2'h0, `IDX_EXP_CAP_HDR}: reg_select = `SEL_HDR;
          {2'h0, `IDX_DEV_CAP}: reg_select = `SEL_DCAP;
          {2'h0, `IDX_DEV_CTRL}: reg_select = `SEL_DCTL;
          {2'h0, `IDX_DEV_STAT}: reg_select = `SEL_DSTA;
          {2'h0, `IDX_LINK_CAP}: reg_select = `SEL_LCAP;
          {2'h0, `IDX_LINK_CTRL}: reg_select = `SEL_LCTL;
          default: reg_select = `SEL_NONE;
        endcase
      end
    end
  endfunction

  // Size code to bytes; reserved codes clamp to the largest size
  function [`SIZE_W-1:0] size_bytes;
    input [2:0] code;
    begin
      if (code > `MRRS_MAX_CODE) begin
        size_bytes = `SIZE_128 << `MRRS_MAX_CODE;
      end else begin
        size_bytes = `SIZE_128 << code;
      end
    end
  endfunction

  // Access is answered one cycle after setup, so every transfer is 2 cycles
  assign setup_phase = psel && !penable;
  assign sel = reg_select(paddr);
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign err_events = {err_unsupported, err_fatal, err_nonfatal,
                       err_correctable};
  // Status clears are write-one; zero bits in the write leave status alone
  assign w1c = (wr_en && (sel == `SEL_DSTA)) ?
               pwdata[`DSTA_ERR_HI:`DSTA_ERR_LO] : 4'h0;

  // APB answer: ready, error and read data all latched in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= (sel == `SEL_NONE);
      prdata <= rdata_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Read mux; reserved and fixed fields are constants
  always @* begin
    rdata_next = 32'h00000000;
    case (sel)
      `SEL_HDR: begin
        rdata_next[7:4] = `HDR_PORT_TYPE;
        rdata_next[3:0] = `HDR_CAP_VER;
      end
      `SEL_DCAP: begin
        rdata_next[27:26] = slot_scale_reg;
        rdata_next[25:18] = slot_value_reg;
        rdata_next[14:12] = `DCAP_IND_BITS;
        rdata_next[11:9] = `DCAP_L1_ACC_LAT;
        rdata_next[8:6] = `DCAP_L0S_ACC_LAT;
        rdata_next[5] = `DCAP_EXT_TAG;
        rdata_next[4:3] = `DCAP_PHANTOM;
        rdata_next[2:0] = `DCAP_MPS_SUP;
      end
      `SEL_DCTL: begin
        // Bits 11, 9, 8 and 4 are never assigned, so they always read zero
        rdata_next[`DCTL_MRRS_HI:`DCTL_MRRS_LO] = mrrs_reg;
        rdata_next[`DCTL_AUX_BIT] = aux_en_reg;
        rdata_next[`DCTL_MPS_HI:`DCTL_MPS_LO] = mps_reg;
        rdata_next[`DCTL_EN_HI:`DCTL_EN_LO] = err_en_reg;
      end
      `SEL_DSTA: begin
        rdata_next[5] = pending;
        rdata_next[4] = aux_det_reg;
        rdata_next[`DSTA_ERR_HI:`DSTA_ERR_LO] = err_stat_reg;
      end
      `SEL_LCAP: begin
        rdata_next[31:24] = port_num_reg;
        rdata_next[17:15] = l1_exit_code;
        rdata_next[14:12] = l0s_exit_code;
        rdata_next[11:10] = `LCAP_ASPM_SUP;
        rdata_next[9:4] = `LCAP_WIDTH;
        rdata_next[3:0] = `LCAP_SPEED;
      end
      `SEL_LCTL: begin
        rdata_next[`LCTL_XSYNC_BIT] = xsync_reg;
        rdata_next[`LCTL_CCLK_BIT] = cclk_reg;
        rdata_next[3] = `LCTL_RCB_128;
        rdata_next[`LCTL_ASPM_HI:`LCTL_ASPM_LO] = aspm_reg;
      end
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Device control; only the defined writable fields take writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrrs_reg <= `DCTL_MRRS_RST;
      mps_reg <= `DCTL_MPS_128;
      err_en_reg <= 4'h0;
    end else if (func_reset) begin
      mrrs_reg <= `DCTL_MRRS_RST;
      mps_reg <= `DCTL_MPS_128;
      err_en_reg <= 4'h0;
    end else if (wr_en && (sel == `SEL_DCTL)) begin
      // No storage stands behind bits 11, 9, 8 and 4, so writes vanish
      mrrs_reg <= pwdata[`DCTL_MRRS_HI:`DCTL_MRRS_LO];
      if (pwdata[`DCTL_MPS_HI:`DCTL_MPS_LO] == `DCTL_MPS_128) begin
        mps_reg <= `DCTL_MPS_128;
      end
      err_en_reg <= pwdata[`DCTL_EN_HI:`DCTL_EN_LO];
    end
  end

  // Aux enable is fixed; function reset deliberately leaves it alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_en_reg <= 1'b1;
    end else begin
      aux_en_reg <= aux_en_reg;
    end
  end

  // Sticky error status: a new event beats a same-cycle clear
  always @* begin
    err_stat_next = (err_stat_reg & ~w1c) | err_events;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_stat_reg <= 4'h0;
    end else if (func_reset) begin
      err_stat_reg <= err_events;
    end else begin
      err_stat_reg <= err_stat_next;
    end
  end

  // Reports go out only for enabled classes, one cycle after the event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_unsupported <= 1'b0;
      report_fatal <= 1'b0;
      report_nonfatal <= 1'b0;
      report_correctable <= 1'b0;
    end else begin
      report_unsupported <= err_unsupported && err_en_reg[3];
      report_fatal <= err_fatal && err_en_reg[2];
      report_nonfatal <= err_nonfatal && err_en_reg[1];
      report_correctable <= err_correctable && err_en_reg[0];
    end
  end

  // Hardware-maintained fields; bus writes never reach them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_scale_reg <= 2'h0;
      slot_value_reg <= 8'h00;
      port_num_reg <= 8'h00;
      aux_det_reg <= 1'b0;
    end else begin
      if (slot_power_set) begin
        slot_scale_reg <= slot_power_scale_in;
        slot_value_reg <= slot_power_value_in;
      end
      // Port number follows its pins every cycle; there is no bus path
      port_num_reg <= port_number_in;
      aux_det_reg <= aux_power_present;
    end
  end

  // Link control; a reserved power management code keeps the old one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xsync_reg <= 1'b0;
      cclk_reg <= 1'b0;
      aspm_reg <= 2'h0;
    end else if (func_reset) begin
      xsync_reg <= 1'b0;
      cclk_reg <= 1'b0;
      aspm_reg <= 2'h0;
    end else if (wr_en && (sel == `SEL_LCTL)) begin
      xsync_reg <= pwdata[`LCTL_XSYNC_BIT];
      cclk_reg <= pwdata[`LCTL_CCLK_BIT];
      if (pwdata[`LCTL_ASPM_HI:`LCTL_ASPM_LO] != `LCTL_ASPM_RSVD) begin
        aspm_reg <= pwdata[`LCTL_ASPM_HI:`LCTL_ASPM_LO];
      end
    end
  end

  // Control outputs toward the transaction and link layers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_request_limit <= `SIZE_128 << `DCTL_MRRS_RST;
      payload_limit <= `SIZE_128;
      extended_sync <= 1'b0;
      common_clock <= 1'b0;
      aspm_control <= 2'h0;
      aux_pm_enable <= 1'b1;
      l0s_exit_code <= L0S_EXIT_ASYNC;
      l1_exit_code <= L1_EXIT_ASYNC;
    end else begin
      read_request_limit <= size_bytes(mrrs_reg);
      payload_limit <= size_bytes(mps_reg);
      extended_sync <= xsync_reg;
      common_clock <= cclk_reg;
      aspm_control <= aspm_reg;
      aux_pm_enable <= aux_en_reg;
      l0s_exit_code <= cclk_reg ? L0S_EXIT_COMMON : L0S_EXIT_ASYNC;
      l1_exit_code <= cclk_reg ? L1_EXIT_COMMON : L1_EXIT_ASYNC;
    end
  end

  // Received payload check against the programmed payload size
  // A payload equal to the limit is legal; only longer ones are flagged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_payload_oversize <= 1'b0;
    end else begin
      rx_payload_oversize <= rx_payload_valid &&
                             (rx_payload_len > size_bytes(mps_reg));
    end
  end

  // Outstanding non-posted request tracking
  pending_tracker #(
    .CNT_W(PEND_CNT_W)
  ) u_pending (
    .pclk(pclk),
    .presetn(presetn),
    .clear(func_reset),
    .issue(np_request_issued),
    .complete(np_completion_done),
    .pending_reg(pending)
  );

endmodule // pcie_endpoint_capability_regs

// [hw/pending_tracker.v]
// Counts non-posted requests still waiting for their completion
module pending_tracker #(
  parameter CNT_W = 6
) (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire issue,
  input wire complete,
  output reg pending_reg
);

  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;

  // Issue and completion in one cycle cancel; underflow is held off
  always @* begin
    count_next = count_reg;
    if (issue && !complete) begin
      count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (complete && !issue && (count_reg != {CNT_W{1'b0}})) begin
      count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Flag drops once the last completion is back, or on a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {CNT_W{1'b0}};
      pending_reg <= 1'b0;
    end else if (clear) begin
      count_reg <= {CNT_W{1'b0}};
      pending_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pending_reg <= (count_next != {CNT_W{1'b0}});
    end
  end

endmodule // pending_tracker

// [testbench/apb_host_model.sv]
module apb_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Request held until pready seen; only the bench timeout ends a wait
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // apb_host_model

// [testbench/pcie_endpoint_capability_regs_props.sv]
module cap_regs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic err_fatal,
  input wire logic report_fatal,
  input wire logic [12:0] rx_payload_len,
  input wire logic rx_payload_valid,
  input wire logic rx_payload_oversize,
  input wire logic [12:0] read_request_limit,
  input wire logic [12:0] payload_limit,
  input wire logic aux_pm_enable,
  input wire logic [1:0] aspm_control,
  input wire logic [2:0] l0s_exit_code,
  input wire logic [2:0] l1_exit_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Slave answers in the first access cycle, then drops
  ready_pulse_a:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  slverr_ready_a:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  report_cause_a:
    assert property (report_fatal |-> $past(err_fatal))
    else $error("fatal report without event");
  oversize_set_a:
    assert property (rx_payload_valid && rx_payload_len > 13'h0080
      |=> rx_payload_oversize)
    else $error("oversize payload not flagged");
  oversize_cause_a:
    assert property (rx_payload_oversize |-> $past(rx_payload_valid)
      && $past(rx_payload_len) > 13'h0080)
    else $error("oversize flag without cause");
  fixed_outputs_a:
    assert property (payload_limit == 13'h0080 && aux_pm_enable)
    else $error("payload limit or aux enable moved");
  limit_range_a:
    assert property ($onehot(read_request_limit)
      && read_request_limit inside {[13'h0080:13'h1000]})
    else $error("read request limit out of range");
  aspm_legal_a:
    assert property (aspm_control != 2'h2)
    else $error("reserved aspm code taken");
  exit_codes_a:
    assert property (l0s_exit_code == 3'h2 && l1_exit_code == 3'h7)
    else $error("exit latency codes wrong");
  cover property (report_fatal);
  cover property (rx_payload_oversize);
  cover property (pslverr);
  cover property (read_request_limit == 13'h1000);
endmodule // cap_regs_checker

bind pcie_endpoint_capability_regs cap_regs_checker u_cap_regs_checker (.*);

// [testbench/tb_pcie_endpoint_capability_regs.sv]
module tb_pcie_endpoint_capability_regs;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, ex, got) begin \
    compares++; \
    if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic func_reset = 1'b0;
  logic slot_power_set = 1'b0;
  logic [1:0] slot_power_scale_in = 2'h0;
  logic [7:0] slot_power_value_in = 8'h00;
  logic [7:0] port_number_in = 8'h5a;
  logic aux_power_present = 1'b1;
  logic np_request_issued = 1'b0;
  logic np_completion_done = 1'b0;
  logic [3:0] err = 4'h0;
  logic [12:0] rx_payload_len = 13'h0000;
  logic rx_payload_valid = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, rx_payload_oversize;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [12:0] read_request_limit, payload_limit;
  wire [3:0] rep;
  wire extended_sync, common_clock, aux_pm_enable;
  wire [1:0] aspm_control;
  wire [2:0] l0s_exit_code, l1_exit_code;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] r;
  logic e;
  // Reads, writes and refusals: write, address, data, expected, slverr
  row_t rows [17] = '{
    '{1'b0, 12'h388, 32'h0, 32'h11, 1'b0},
    '{1'b0, 12'h390, 32'h0, 32'hfc0, 1'b0},
    '{1'b0, 12'h3a0, 32'h0, 32'h2400, 1'b0},
    '{1'b0, 12'h3a8, 32'h0, 32'h10, 1'b0},
    '{1'b0, 12'h3b0, 32'h0, 32'h5a03a411, 1'b0},
    '{1'b0, 12'h3c0, 32'h0, 32'h8, 1'b0},
    '{1'b1, 12'h390, '1, 32'h0, 1'b0},
    '{1'b1, 12'h3b0, '1, 32'h0, 1'b0},
    '{1'b0, 12'h390, 32'h0, 32'hfc0, 1'b0},
    '{1'b0, 12'h3b0, 32'h0, 32'h5a03a411, 1'b0},
    '{1'b1, 12'h3a0, 32'hffff, 32'h0, 1'b0},
    '{1'b0, 12'h3a0, 32'h0, 32'h740f, 1'b0},
    '{1'b1, 12'h3c0, 32'hffff, 32'h0, 1'b0},
    '{1'b0, 12'h3c0, 32'h0, 32'hcb, 1'b0},
    '{1'b1, 12'h3c0, 32'h2, 32'h0, 1'b0},
    '{1'b0, 12'h3c0, 32'h0, 32'hb, 1'b0},
    '{1'b0, 12'h3a4, 32'h0, 32'h0, 1'b1}
  };
  apb_host_model u_apb_host_model (.pclk, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  pcie_endpoint_capability_regs u_pcie_endpoint_capability_regs (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .func_reset, .slot_power_set, .slot_power_scale_in,
    .slot_power_value_in, .port_number_in, .aux_power_present,
    .np_request_issued, .np_completion_done, .err_unsupported(err[3]),
    .err_fatal(err[2]), .err_nonfatal(err[1]), .err_correctable(err[0]),
    .rx_payload_len, .rx_payload_valid, .rx_payload_oversize,
    .read_request_limit, .payload_limit, .report_unsupported(rep[3]),
    .report_fatal(rep[2]), .report_nonfatal(rep[1]),
    .report_correctable(rep[0]), .extended_sync, .common_clock,
    .aspm_control, .aux_pm_enable, .l0s_exit_code, .l1_exit_code);
  always #10 pclk = ~pclk;
  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far above the roughly 160 cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_apb_host_model.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    u_apb_host_model.xfer(1'b0, a, 32'h0, r, e);
    `CHK("rdata", x, r)
  endtask
  // One-cycle error event, then the cycle where reports show
  task automatic fire(input logic [3:0] m);
    err <= m;
    @(posedge pclk);
    err <= 4'h0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("rrl_rst", 13'h0200, read_request_limit)
    `CHK("aux_en", 1'b1, aux_pm_enable)
    foreach (rows[i]) begin
      u_apb_host_model.xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
      `CHK("pslverr", rows[i].e, e)
      if (!rows[i].w)
        `CHK("row_rdata", rows[i].x, r)
    end
    `CHK("aspm", 2'h3, aspm_control)
    `CHK("xsync", 1'b0, extended_sync)
    wr(12'h3c0, 32'hc1);
    @(posedge pclk); // Output copies trail the register by one edge
    `CHK("xsync", 1'b1, extended_sync)
    `CHK("cclk", 1'b1, common_clock)
    `CHK("aspm1", 2'h1, aspm_control)
    `CHK("l0s", 3'h2, l0s_exit_code)
    // Every read request code, reserved ones clamp at the top
    for (int c = 0; c < 8; c++) begin
      wr(12'h3a0, c << 12);
      @(posedge pclk); // Limit output trails the code by one edge
      `CHK("rrl", 13'h0080 << (c > 5 ? 5 : c), read_request_limit)
    end
    wr(12'h3a0, 32'h0);
    fire(4'hf);
    `CHK("rep_off", 4'h0, rep)
    rd(12'h3a8, 32'h1f);
    wr(12'h3a8, 32'hf);
    rd(12'h3a8, 32'h10);
    wr(12'h3a0, 32'hf);
    for (int b = 0; b < 4; b++) begin
      fire(4'h1 << b);
      `CHK("rep_on", 4'h1 << b, rep)
    end
    // Two requests outstanding, completed one at a time
    aux_power_present <= 1'b0;
    np_request_issued <= 1'b1;
    repeat (2) @(posedge pclk);
    np_request_issued <= 1'b0;
    np_completion_done <= 1'b1;
    @(posedge pclk);
    np_completion_done <= 1'b0;
    rd(12'h3a8, 32'h2f);
    np_completion_done <= 1'b1;
    @(posedge pclk);
    np_completion_done <= 1'b0;
    @(posedge pclk);
    rd(12'h3a8, 32'hf);
    slot_power_scale_in <= 2'h3;
    slot_power_value_in <= 8'ha5;
    slot_power_set <= 1'b1;
    @(posedge pclk);
    slot_power_set <= 1'b0;
    rd(12'h390, 32'h0e940fc0);
    rx_payload_len <= 13'h0081;
    rx_payload_valid <= 1'b1;
    @(posedge pclk);
    rx_payload_len <= 13'h0080;
    @(posedge pclk);
    `CHK("oversize", 1'b1, rx_payload_oversize)
    rx_payload_valid <= 1'b0;
    @(posedge pclk);
    `CHK("fits", 1'b0, rx_payload_oversize)
    func_reset <= 1'b1;
    @(posedge pclk);
    func_reset <= 1'b0;
    rd(12'h3a0, 32'h2400);
    rd(12'h3a8, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h3c0, 32'h8);
    close_out();
  end
endmodule // tb_pcie_endpoint_capability_regs
